// >>> core/dcrd_pkg.sv
// constants, field layouts and carrier types for the configuration word decoder
package dcrd_pkg;

    // serial word framing
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
    localparam logic [CNT_W-1:0] FRAME_SAT = 5'h11;
    localparam logic [CNT_W-1:0] FRAME_FIRST = 5'h01;

    // word header in bits 15..13
    localparam int HDR_HI = 15;
    localparam int HDR_LO = 13;
    localparam logic [2:0] HDR_CHAN = 3'h1;
    localparam logic [2:0] HDR_WDOG = 3'h2;
    localparam logic [2:0] HDR_BOOST = 3'h3;
    localparam logic [2:0] HDR_SOFT = 3'h4;

    // software command word
    localparam int CHECK_BIT = 12;
    localparam int CODE_HI = 11;
    localparam int CODE_LO = 0;
    localparam logic [11:0] CODE_RESET = 12'h555;
    localparam logic [11:0] CODE_KEEPALIVE = 12'h195;

    // channel control word and watchdog control word
    localparam int CHAN_HI = 12;
    localparam int CHAN_LO = 11;
    localparam int OVR_BIT = 3;
    localparam int RANGE_HI = 2;
    localparam int RANGE_LO = 0;
    localparam int WDOG_EN_BIT = 0;

    // boost converter control word
    localparam int COMP_BIT = 6;
    localparam int EDGE_HI = 5;
    localparam int EDGE_LO = 4;
    localparam int RATE_HI = 3;
    localparam int RATE_LO = 2;
    localparam int VLIM_HI = 1;
    localparam int VLIM_LO = 0;

    localparam int NCH = 4;

    typedef enum logic [2:0] {
        RNG_UNI_5V = 3'h0,
        RNG_UNI_10V = 3'h1,
        RNG_BIP_5V = 3'h2,
        RNG_BIP_10V = 3'h3,
        RNG_4_20MA = 3'h4,
        RNG_0_20MA = 3'h5,
        RNG_0_24MA = 3'h6,
        RNG_RESERVED = 3'h7
    } dcrd_range_t;

    localparam logic [1:0] EDGE_SAME = 2'h0;
    localparam logic [1:0] EDGE_AB_CD = 2'h1;
    localparam logic [1:0] EDGE_AC_BD = 2'h2;
    localparam logic [1:0] EDGE_QUAD = 2'h3;
    localparam logic [1:0] QTR_NONE = 2'h0;
    localparam logic [1:0] QTR_HALF = 2'h2;

    // switching rate divisors from the internal oscillator, rounded to nearest
    localparam int OSC_KHZ = 13000;
    localparam int RATE0_KHZ = 250;
    localparam int RATE1_KHZ = 410;
    localparam int RATE2_KHZ = 650;
    localparam logic [5:0] DIV_RATE0 = 6'((OSC_KHZ + RATE0_KHZ / 2) / RATE0_KHZ);
    localparam logic [5:0] DIV_RATE1 = 6'((OSC_KHZ + RATE1_KHZ / 2) / RATE1_KHZ);
    localparam logic [5:0] DIV_RATE2 = 6'((OSC_KHZ + RATE2_KHZ / 2) / RATE2_KHZ);
    localparam logic [1:0] RATE_CODE0 = 2'h0;
    localparam logic [1:0] RATE_CODE1 = 2'h1;
    localparam logic [1:0] RATE_CODE2 = 2'h2;

    typedef struct packed {
        logic boost_compensation_select;
        logic [1:0] boost_edge_select;
        logic [1:0] boost_switching_rate;
        logic [1:0] boost_voltage_limit;
    } dcrd_boost_t;

    localparam dcrd_boost_t BOOST_RESET = '{1'b0, EDGE_SAME, RATE_CODE1, 2'h0};

    // watchdog timing
    localparam int CLK_MHZ = 25;
    localparam int WD_TIMEOUT_US = 5000;
    localparam int WD_CYCLES = WD_TIMEOUT_US * CLK_MHZ;
    localparam int WD_W = 20;

endpackage : dcrd_pkg

// >>> core/dcrd_decode.sv
// serial configuration word capture and register decode
`timescale 1ns/100ps

// How it works
// - codes 0..3 pick the four voltage ranges
// - codes 4..6 pick the three current ranges
// - per channel overrange enable, cleared at reset
// - overrange only acts on voltage ranges
// - header 100 marks a software command word
// - bit 12 turns packet checking on/off
// - code 0x555 resets the core registers, keeping the synchroniser and frame state
// - missing keep-alive 0x195 raises the fault alert
// - header 011 marks boost word, 12..7 ignored
// - boost compensation, edge, rate from bits 6..2
// - boost voltage limit from bits 1..0
// - edge code sets per-channel switching phase
// - rate code picks oscillator divisor, 410 default
module dcrd_decode
    import dcrd_pkg::*;
#(
    parameter int WD_LIMIT = WD_CYCLES
)
(
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // serial link
    input wire logic link_sclk,
    input wire logic sync_n,
    input wire logic serial_data_in,
    // channel configuration
    output logic [NCH-1:0][2:0] output_range_select,
    output logic [NCH-1:0] overrange_enable,
    output logic [NCH-1:0] chan_is_current,
    output logic [NCH-1:0] overrange_active,
    // boost converter
    output dcrd_boost_t boost_cfg,
    output logic [NCH-1:0][1:0] boost_phase_quarter,
    output logic [5:0] boost_divisor,
    // command and watchdog status
    output logic packet_check,
    output logic watchdog_enable,
    output logic fault_alert,
    output logic soft_reset_pulse,
    output logic word_taken
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [WORD_W-1:0] shift;
    } dcrd_link_t;

    typedef struct packed {
        logic [2:0] sync_pipe;
        logic frame_idle;
        logic word_stb;
        logic [WORD_W-1:0] word;
        logic [NCH-1:0][2:0] range;
        logic [NCH-1:0] ovr;
        logic [NCH-1:0] is_cur;
        logic [NCH-1:0] ovr_act;
        dcrd_boost_t boost;
        logic [NCH-1:0][1:0] quarter;
        logic [5:0] divisor;
        logic pkt_chk;
        logic wd_en;
        logic [WD_W-1:0] wd_cnt;
        logic alert;
        logic soft_rst;
    } dcrd_core_t;

    localparam dcrd_core_t CORE_RESET = '{
        sync_pipe: 3'h7,
        frame_idle: 1'b1,
        word_stb: 1'b0,
        word: 16'h0000,
        range: '0,
        ovr: '0,
        is_cur: '0,
        ovr_act: '0,
        boost: BOOST_RESET,
        quarter: '0,
        divisor: DIV_RATE1,
        pkt_chk: 1'b0,
        wd_en: 1'b0,
        wd_cnt: '0,
        alert: 1'b0,
        soft_rst: 1'b0
    };

    localparam logic [WD_W-1:0] WD_LAST = WD_W'(WD_LIMIT - 1);

    function automatic logic [1:0] phase_of(input logic [1:0] edge_code, input int ch);
        logic [1:0] q;
        q = QTR_NONE;
        case (edge_code)
            EDGE_AB_CD: q = (ch >= 2) ? QTR_HALF : QTR_NONE;
            EDGE_AC_BD: q = (ch % 2 == 1) ? QTR_HALF : QTR_NONE;
            EDGE_QUAD: q = 2'(ch);
            default: q = QTR_NONE;
        endcase
        return q;
    endfunction : phase_of

    function automatic logic [5:0] divisor_of(input logic [1:0] rate);
        logic [5:0] d;
        d = DIV_RATE1;
        if (rate == RATE_CODE0)
            d = DIV_RATE0;
        else if (rate == RATE_CODE2)
            d = DIV_RATE2;
        return d;
    endfunction : divisor_of

    // ---------------- link domain ----------------
    dcrd_link_t link_r;
    dcrd_link_t link_nxt;
    logic fresh_r;

    // raised asynchronously while the frame line is idle, so the first clock of a frame
    // restarts the bit count even though the link clock may not run between frames
    always_ff @(posedge link_sclk or posedge sync_n)
    begin
        if (sync_n)
            fresh_r <= 1'b1;
        else
            fresh_r <= 1'b0;
    end

    always_comb
    begin
        link_nxt = link_r;
        if (!sync_n)
        begin
            link_nxt.shift = {link_r.shift[WORD_W-2:0], serial_data_in};
            if (fresh_r)
                link_nxt.cnt = FRAME_FIRST;
            else if (link_r.cnt != FRAME_SAT)
                link_nxt.cnt = link_r.cnt + 5'h01;
        end
    end

    always_ff @(posedge link_sclk)
    begin
        link_r <= link_nxt;
    end

    // ---------------- core domain ----------------
    dcrd_core_t cur_r;
    dcrd_core_t cur_nxt;

    logic [2:0] w_hdr;
    logic [1:0] w_ch;
    logic [2:0] w_range;
    logic [11:0] w_code;
    logic soft_word;
    logic keepalive;
    logic wd_expire;

    assign w_hdr = cur_r.word[HDR_HI:HDR_LO];
    assign w_ch = cur_r.word[CHAN_HI:CHAN_LO];
    assign w_range = cur_r.word[RANGE_HI:RANGE_LO];
    assign w_code = cur_r.word[CODE_HI:CODE_LO];
    assign soft_word = cur_r.word_stb && (w_hdr == HDR_SOFT);
    // keep-alive only matters while the watchdog runs
    assign keepalive = soft_word && (w_code == CODE_KEEPALIVE) && cur_r.wd_en;
    assign wd_expire = cur_r.wd_en && (cur_r.wd_cnt == WD_LAST) && !keepalive;

    always_comb
    begin
        cur_nxt = cur_r;
        // first stage only feeds the second
        cur_nxt.sync_pipe = {cur_r.sync_pipe[1:0], sync_n};
        cur_nxt.word_stb = 1'b0;
        cur_nxt.soft_rst = 1'b0;
        if (cur_r.sync_pipe[1] == cur_r.sync_pipe[2])
            cur_nxt.frame_idle = cur_r.sync_pipe[2];
        // link words are stable once the frame line has gone idle; short frames are dropped
        if (!cur_r.frame_idle && cur_nxt.frame_idle && link_r.cnt == FRAME_BITS)
        begin
            cur_nxt.word_stb = 1'b1;
            cur_nxt.word = link_r.shift;
        end
        if (cur_r.word_stb)
        begin
            if (w_hdr == HDR_CHAN)
            begin
                if (w_range != RNG_RESERVED)
                    cur_nxt.range[w_ch] = w_range;
                cur_nxt.ovr[w_ch] = cur_r.word[OVR_BIT];
            end
            else if (w_hdr == HDR_WDOG)
            begin
                cur_nxt.wd_en = cur_r.word[WDOG_EN_BIT];
                cur_nxt.wd_cnt = '0;
            end
            else if (w_hdr == HDR_BOOST)
            begin
                cur_nxt.boost.boost_compensation_select = cur_r.word[COMP_BIT];
                cur_nxt.boost.boost_edge_select = cur_r.word[EDGE_HI:EDGE_LO];
                cur_nxt.boost.boost_switching_rate = cur_r.word[RATE_HI:RATE_LO];
                cur_nxt.boost.boost_voltage_limit = cur_r.word[VLIM_HI:VLIM_LO];
            end
            else if (w_hdr == HDR_SOFT)
            begin
                cur_nxt.pkt_chk = cur_r.word[CHECK_BIT];
            end
        end
        // watchdog: counter reloads on keep-alive, alert clear wins over its set
        if (!cur_r.wd_en)
            cur_nxt.wd_cnt = '0;
        else if (keepalive || wd_expire)
            cur_nxt.wd_cnt = '0;
        else
            cur_nxt.wd_cnt = cur_r.wd_cnt + WD_W'(1);
        cur_nxt.alert = wd_expire || (cur_r.alert && !keepalive);
        // derived outputs are registered so the analog side sees glitch-free levels
        for (int i = 0; i < NCH; i++)
        begin
            cur_nxt.is_cur[i] = cur_nxt.range[i][2];
            cur_nxt.ovr_act[i] = cur_nxt.ovr[i] && !cur_nxt.range[i][2];
            cur_nxt.quarter[i] = phase_of(cur_nxt.boost.boost_edge_select, i);
        end
        cur_nxt.divisor = divisor_of(cur_nxt.boost.boost_switching_rate);
        // full reset by command keeps the synchroniser so the frame state stays coherent
        if (soft_word && w_code == CODE_RESET)
        begin
            cur_nxt = CORE_RESET;
            cur_nxt.sync_pipe = {cur_r.sync_pipe[1:0], sync_n};
            cur_nxt.frame_idle = cur_r.frame_idle;
            cur_nxt.soft_rst = 1'b1;
        end
        if (rst)
            cur_nxt = CORE_RESET;
    end

    always_ff @(posedge core_clk)
    begin
        cur_r <= cur_nxt;
    end

    assign output_range_select = cur_r.range;
    assign overrange_enable = cur_r.ovr;
    assign chan_is_current = cur_r.is_cur;
    assign overrange_active = cur_r.ovr_act;
    assign boost_cfg = cur_r.boost;
    assign boost_phase_quarter = cur_r.quarter;
    assign boost_divisor = cur_r.divisor;
    assign packet_check = cur_r.pkt_chk;
    assign watchdog_enable = cur_r.wd_en;
    assign fault_alert = cur_r.alert;
    assign soft_reset_pulse = cur_r.soft_rst;
    assign word_taken = cur_r.word_stb;

    // ---------------- checks ----------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic chan_word;
    logic is_reset_cmd;
    assign chan_word = word_taken && (w_hdr == HDR_CHAN);
    assign is_reset_cmd = soft_word && (w_code == CODE_RESET);

    AST_RESET_DEFAULTS: assert property (disable iff (1'b0)
        rst |=> output_range_select == '0 && overrange_enable == '0 && boost_cfg == BOOST_RESET)
        else $error("reset defaults wrong");

    AST_RANGE_LOAD: assert property (
        chan_word && w_range != RNG_RESERVED && !is_reset_cmd
        |=> output_range_select[$past(w_ch)] == $past(w_range))
        else $error("range not loaded");

    AST_RANGE_RSVD_KEEP: assert property (
        chan_word && w_range == RNG_RESERVED
        |=> output_range_select[$past(w_ch)] == $past(output_range_select[w_ch]))
        else $error("reserved range changed channel");

    AST_OVR_LOAD: assert property (
        chan_word |=> overrange_enable[$past(w_ch)] == $past(cur_r.word[OVR_BIT]))
        else $error("overrange enable not loaded");

    AST_CHECK_LOAD: assert property (
        soft_word && !is_reset_cmd |=> packet_check == $past(cur_r.word[CHECK_BIT]))
        else $error("packet check flag wrong");

    AST_CHECK_ONLY_SOFT: assert property (
        word_taken && w_hdr != HDR_SOFT |=> $stable(packet_check))
        else $error("packet check changed by other word");

    AST_SOFT_RESET: assert property (
        is_reset_cmd |=> soft_reset_pulse && output_range_select == '0 && !packet_check
            ##1 !soft_reset_pulse)
        else $error("command reset not performed");

    AST_SOFT_PULSE_CAUSE: assert property (
        soft_reset_pulse |-> $past(is_reset_cmd))
        else $error("reset pulse without reset command");

    // a command reset in the expiry cycle wins, since it loads the reset values, alert included
    AST_ALERT_EXPIRE: assert property (
        wd_expire && !is_reset_cmd |=> fault_alert)
        else $error("alert not raised at timeout");

    AST_ALERT_CLEAR: assert property (
        keepalive |=> !fault_alert)
        else $error("alert not cleared by keep-alive");

    AST_ALERT_CAUSE: assert property (
        $rose(fault_alert) |-> $past(cur_r.wd_en) && $past(cur_r.wd_cnt) == WD_LAST)
        else $error("alert raised without timeout");

    AST_BOOST_LOAD: assert property (
        word_taken && w_hdr == HDR_BOOST
        |=> boost_cfg == dcrd_boost_t'($past(cur_r.word[COMP_BIT:VLIM_LO])))
        else $error("boost fields not loaded");

    AST_BOOST_ONLY_HDR: assert property (
        word_taken && w_hdr != HDR_BOOST && !is_reset_cmd |=> $stable(boost_cfg))
        else $error("boost fields changed by other word");

    AST_DIVISOR: assert property (
        boost_cfg.boost_switching_rate == RATE_CODE1 |-> boost_divisor == DIV_RATE1)
        else $error("divisor mismatch");

    AST_PHASE_QUAD: assert property (
        boost_cfg.boost_edge_select == EDGE_QUAD |-> boost_phase_quarter[NCH-1] == 2'h3)
        else $error("quarter spacing wrong");

    for (genvar g = 0; g < NCH; g++)
    begin : g_chk
        AST_OVR_VOLT_ONLY: assert property (
            overrange_active[g] == (overrange_enable[g] && !output_range_select[g][2]))
            else $error("overrange active on current range");
        AST_CURRENT_FLAG: assert property (
            chan_is_current[g] == output_range_select[g][2])
            else $error("current range flag wrong");
    end

    COV_SOFT_RESET: cover property (is_reset_cmd ##1 soft_reset_pulse);
    COV_ALERT: cover property ($rose(fault_alert));
    COV_KEEPALIVE: cover property (keepalive);
    COV_BOOST: cover property (word_taken && w_hdr == HDR_BOOST);

endmodule : dcrd_decode

// >>> tb/dcrd_host.sv
// host side of the serial link: shifts configuration words into the decoder
`timescale 1ns/100ps
module dcrd_host
(
    // serial link toward the decoder
    output logic link_sclk,
    output logic sync_n,
    output logic serial_data_in
);
    initial
    begin
        link_sclk = 1'b0;
        sync_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // clock stands still between frames; data then shows the inverse of the last bit
    // so a stale level can never pass for a fresh one
    task automatic send_word(input logic [23:0] w, input int n);
        #7;
        sync_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_data_in = w[i];
            #24;
            link_sclk = 1'b1;
            #24;
            link_sclk = 1'b0;
        end
        #24;
        sync_n = 1'b1;
        serial_data_in = ~serial_data_in;
    endtask : send_word
endmodule : dcrd_host

// >>> tb/testbench.sv
// self-checking bench for the configuration word decoder
`timescale 1ns/100ps
module testbench;
    import dcrd_pkg::*;
    // short watchdog limit keeps the run brief
    localparam int WDL = 60;
    logic core_clk;
    logic rst;
    logic link_sclk;
    logic sync_n;
    logic serial_data_in;
    logic [NCH-1:0][2:0] rng;
    logic [NCH-1:0] ovr;
    logic [NCH-1:0] is_cur;
    logic [NCH-1:0] ovr_act;
    dcrd_boost_t boost;
    logic [NCH-1:0][1:0] quarter;
    logic [5:0] divisor;
    logic pkt_chk;
    logic wd_en;
    logic alert;
    logic soft_rst;
    logic taken;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int n_soft = 0;
    int n_taken = 0;
    logic [7:0] qexp [4] = '{8'h00, 8'hA0, 8'h88, 8'hE4};
    logic [5:0] dexp [4] = '{6'h34, 6'h20, 6'h14, 6'h20};

    dcrd_decode #(.WD_LIMIT(WDL)) dut (.core_clk(core_clk), .rst(rst),
        .link_sclk(link_sclk), .sync_n(sync_n), .serial_data_in(serial_data_in),
        .output_range_select(rng), .overrange_enable(ovr), .chan_is_current(is_cur),
        .overrange_active(ovr_act), .boost_cfg(boost), .boost_phase_quarter(quarter),
        .boost_divisor(divisor), .packet_check(pkt_chk), .watchdog_enable(wd_en),
        .fault_alert(alert), .soft_reset_pulse(soft_rst), .word_taken(taken));

    dcrd_host host (.link_sclk(link_sclk), .sync_n(sync_n),
        .serial_data_in(serial_data_in));

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // pulses are counted mid-cycle, away from the edge that launches them
    always @(negedge core_clk)
    begin
        cycles++;
        if (soft_rst === 1'b1)
            n_soft++;
        if (taken === 1'b1)
            n_taken++;
        if (cycles >= 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk

    // a word is taken within 5 cycles of the frame end, outputs follow one cycle later
    task automatic send(input logic [23:0] w, input int n, input logic [15:0] n_exp);
        int t0;
        t0 = n_taken;
        host.send_word(w, n);
        repeat (8) @(negedge core_clk);
        chk("word_taken count", 16'(n_taken - t0), n_exp);
        repeat (2) @(negedge core_clk);
    endtask : send

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        rst = 1'b1;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        chk("range", 16'(rng), 16'h0000);
        chk("overrange", 16'(ovr), 16'h0000);
        chk("boost", 16'(boost), 16'(BOOST_RESET));
        chk("divisor", 16'(divisor), 16'h0020);
        $display("finished reset defaults");
        for (int ch = 0; ch < NCH; ch++)
        begin
            for (int c = 0; c < 7; c++)
            begin
                send({8'h00, 3'h1, 2'(ch), 7'h00, 1'(c), 3'(c)}, 16, 16'h0001);
                chk("range", 16'(rng[ch]), 16'(c));
                chk("current", 16'(is_cur[ch]), 16'(c >= 4));
                chk("overrange", 16'(ovr[ch]), 16'(c % 2));
                chk("overrange active", 16'(ovr_act[ch]), 16'((c % 2) && c < 4));
            end
        end
        // reserved range code, sent on purpose
        send({8'h00, 16'h300F}, 16, 16'h0001);
        chk("reserved range", 16'(rng[2]), 16'h0006);
        chk("overrange", 16'(ovr[2]), 16'h0001);
        $display("finished ranges");
        send({8'h00, 16'h9000}, 16, 16'h0001);
        chk("packet check on", 16'(pkt_chk), 16'h0001);
        send({8'h00, 16'h8000}, 16, 16'h0001);
        chk("packet check off", 16'(pkt_chk), 16'h0000);
        send({8'h00, 16'h9000}, 24, 16'h0000);
        send({8'h00, 16'h4800}, 15, 16'h0000);
        chk("long frame dropped", 16'(pkt_chk), 16'h0000);
        $display("finished software word");
        for (int e = 0; e < 4; e++)
        begin
            send({8'h00, 3'h3, 6'h3F, 1'(e), 2'(e), 2'(e), 2'(3 - e)}, 16, 16'h0001);
            chk("boost", 16'(boost), 16'({1'(e), 2'(e), 2'(e), 2'(3 - e)}));
            chk("quarter", 16'(quarter), 16'(qexp[e]));
            chk("divisor", 16'(divisor), 16'(dexp[e]));
        end
        send({8'h00, 16'hFFFF}, 16, 16'h0001);
        chk("unknown header", 16'(boost), 16'h007C);
        $display("finished boost word");
        send({8'h00, 16'h4001}, 16, 16'h0001);
        chk("watchdog", 16'(wd_en), 16'h0001);
        chk("no early alert", 16'(alert), 16'h0000);
        repeat (WDL + 10) @(negedge core_clk);
        chk("alert", 16'(alert), 16'h0001);
        for (int k = 0; k < 4; k++)
        begin
            send({8'h00, 16'h8195}, 16, 16'h0001);
            chk("alert after keep-alive", 16'(alert), 16'h0000);
        end
        send({8'h00, 16'h4000}, 16, 16'h0001);
        repeat (2 * WDL) @(negedge core_clk);
        chk("alert when disabled", 16'(alert), 16'h0000);
        $display("finished watchdog");
        send({8'h00, 16'h9000}, 16, 16'h0001);
        send({8'h00, 16'h4001}, 16, 16'h0001);
        // check bit set in the reset word: the reset must still clear the flag
        send({8'h00, 16'h9555}, 16, 16'h0001);
        chk("reset pulse", 16'(n_soft), 16'h0001);
        chk("range", 16'(rng), 16'h0000);
        chk("overrange", 16'(ovr), 16'h0000);
        chk("boost", 16'(boost), 16'(BOOST_RESET));
        chk("packet check", 16'(pkt_chk), 16'h0000);
        chk("watchdog", 16'(wd_en), 16'h0000);
        $display("finished command reset");
        wrap_up();
    end
endmodule : testbench
